// ---- logic/tfs_pkg.sv ----
`default_nettype none
package tfs_pkg;
  // ---------------------------------------------------------------
  // register indices (printed offsets are not multiples of four)
  // ---------------------------------------------------------------
  localparam logic [7:0] TFS_IDX_DUTY     = 8'h4E;
  localparam logic [7:0] TFS_IDX_TEMP     = 8'h4F;
  localparam logic [7:0] TFS_IDX_OVH      = 8'h50;
  localparam logic [7:0] TFS_IDX_FAN      = 8'h51;
  localparam logic [7:0] TFS_IDX_CTRL     = 8'h52;
  localparam logic [7:0] TFS_IDX_DLIM     = 8'h53;
  localparam logic [7:0] TFS_RST_VAL      = 8'h00;
  localparam logic [7:0] TFS_DLIM_RST     = 8'h00;
  localparam logic [7:0] TFS_PCT_FULL     = 8'h64;
  localparam int         TFS_CTRL_SWRST   = 0;
  localparam int         TFS_WIN_US       = 1000;
  localparam int         TFS_CLK_MHZ      = 250;
  localparam int         TFS_WIN_CYC      = TFS_WIN_US * TFS_CLK_MHZ;

  // ---------------------------------------------------------------
  // per-channel conversion result
  // ---------------------------------------------------------------
  typedef struct packed {
    logic done;
    logic high;
    logic low;
    logic fault;
    logic ovh;
  } tfs_conv_t;
endpackage
`default_nettype wire

// ---- logic/tfs_status_bank.sv ----
// Function
// - duty register shows percent of time overheat line active per window
// - temp status bits 7/6 flag local high and low limit trips
// - temp status bits 5/4 flag first remote high and low trips
// - temp status bit 3 reports first remote diode short or open
// - temp status bits 2/1 flag second remote high and low trips
// - temp status bit 0 reports second remote diode short or open
// - overheat status bits 7/6/5 flag local, remote1, remote2 overheat trips
// - overheat status bit 4 sets when duty exceeds limit, clears on read
// - with zero duty limit and line asserted, bit 4 reasserts immediately
// - overheat status bit 3 flags line pulled low by another party
// - overheat status bit 2 flags device itself driving the line low
// - fan status bit 7 flags first fan stalled
// - fan status bit 5 flags second fan stalled
// - fan status bit 6 flags fans forced to full speed by alarm
// - fan status bit 0 mirrors alert output pulled low
// - temp status read-only, zero at power-on and after software reset
// - overheat status zero at reset; bits 1 and 0 read zero
// - fan status zero at reset; bits 4 to 1 reserved zero
// - duty register zero at reset, cleared by software reset, ignores writes
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module tfs_status_bank
  import tfs_pkg::*;
#(
  parameter int WIN_CYC = TFS_WIN_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire tfs_conv_t   conv_local,
  input  wire tfs_conv_t   conv_rem1,
  input  wire tfs_conv_t   conv_rem2,
  input  wire logic        overheat_line_in,
  input  wire logic        overheat_drive_state,
  input  wire logic        fan1_stall,
  input  wire logic        fan2_stall,
  input  wire logic        fan_alarm_speed,
  input  wire logic        alert_low
);

  // window must hold at least one cycle per percent step
  if (WIN_CYC < int'(TFS_PCT_FULL)) begin : g_bad_win
    $error("window too short for percent resolution");
  end

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [9:0] adr, input logic [7:0] idx);
    hit = (adr[9:2] == idx) && (adr[1:0] == 2'b00);
  endfunction

  logic       req;
  logic       rd_ovh;
  logic       wr_ctrl;
  logic       wr_dlim;
  logic       sw_rst;
  logic [7:0] temp_q;
  logic [7:0] ovh_q;
  logic [7:0] fan_q;
  logic [7:0] duty_q;
  logic [7:0] dlim_q;
  logic [31:0] win_cnt_q;
  logic [31:0] on_cnt_q;
  logic [31:0] lim_cyc;
  logic        line_act;

  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_ovh  = req && !wb_we_i && hit(wb_adr_i, TFS_IDX_OVH);
  assign wr_ctrl = req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, TFS_IDX_CTRL);
  assign wr_dlim = req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, TFS_IDX_DLIM);
  assign sw_rst  = wr_ctrl && wb_dat_i[TFS_CTRL_SWRST];
  assign line_act = !overheat_line_in || overheat_drive_state;

  // ---------------------------------------------------------------
  // bus answer: one cycle after request, data from flops
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        unique case (1'b1)
          hit(wb_adr_i, TFS_IDX_DUTY): wb_dat_o <= {24'h000000, duty_q};
          hit(wb_adr_i, TFS_IDX_TEMP): wb_dat_o <= {24'h000000, temp_q};
          hit(wb_adr_i, TFS_IDX_OVH):  wb_dat_o <= {24'h000000, ovh_q};
          hit(wb_adr_i, TFS_IDX_FAN):  wb_dat_o <= {24'h000000, fan_q};
          hit(wb_adr_i, TFS_IDX_DLIM): wb_dat_o <= {24'h000000, dlim_q};
          default:                     wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dlim_q <= TFS_DLIM_RST;
    end else if (wr_dlim) begin
      dlim_q <= wb_dat_i[7:0];
    end
  end

  // ---------------------------------------------------------------
  // temperature limit status
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_q <= TFS_RST_VAL;
    end else if (sw_rst) begin
      temp_q <= TFS_RST_VAL;
    end else begin
      if (conv_local.done) begin
        temp_q[7] <= conv_local.high;
        temp_q[6] <= conv_local.low;
      end
      if (conv_rem1.done) begin
        temp_q[5] <= conv_rem1.high;
        temp_q[4] <= conv_rem1.low;
        temp_q[3] <= conv_rem1.fault;
      end
      if (conv_rem2.done) begin
        temp_q[2] <= conv_rem2.high;
        temp_q[1] <= conv_rem2.low;
        temp_q[0] <= conv_rem2.fault;
      end
    end
  end

  // ---------------------------------------------------------------
  // duty measurement window
  // ---------------------------------------------------------------
  logic win_end;
  assign win_end = (win_cnt_q == 32'(WIN_CYC - 1));
  assign lim_cyc = 32'((64'(dlim_q) * 64'(WIN_CYC)) / 64'(TFS_PCT_FULL));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt_q <= 32'h0000_0000;
      on_cnt_q  <= 32'h0000_0000;
      duty_q    <= TFS_RST_VAL;
    end else if (sw_rst) begin
      win_cnt_q <= 32'h0000_0000;
      on_cnt_q  <= 32'h0000_0000;
      duty_q    <= TFS_RST_VAL;
    end else if (win_end) begin
      win_cnt_q <= 32'h0000_0000;
      on_cnt_q  <= 32'h0000_0000;
      duty_q    <= 8'(((64'(on_cnt_q) + 64'(line_act)) * 64'(TFS_PCT_FULL))
                      / 64'(WIN_CYC));
    end else begin
      win_cnt_q <= win_cnt_q + 32'h0000_0001;
      on_cnt_q  <= on_cnt_q + 32'(line_act);
    end
  end

  logic exceed;
  assign exceed = line_act && (on_cnt_q >= lim_cyc);

  // ---------------------------------------------------------------
  // overheat event status
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovh_q <= TFS_RST_VAL;
    end else if (sw_rst) begin
      ovh_q <= TFS_RST_VAL;
    end else begin
      if (conv_local.done) ovh_q[7] <= conv_local.ovh;
      if (conv_rem1.done)  ovh_q[6] <= conv_rem1.ovh;
      if (conv_rem2.done)  ovh_q[5] <= conv_rem2.ovh;
      // set wins over read clear, so zero limit reasserts at once
      if (exceed) begin
        ovh_q[4] <= 1'b1;
      end else if (rd_ovh) begin
        ovh_q[4] <= 1'b0;
      end
      ovh_q[3]   <= !overheat_line_in && !overheat_drive_state;
      ovh_q[2]   <= overheat_drive_state;
      ovh_q[1:0] <= 2'b00;
    end
  end

  // ---------------------------------------------------------------
  // fan alarm status
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fan_q <= TFS_RST_VAL;
    end else if (sw_rst) begin
      fan_q <= TFS_RST_VAL;
    end else begin
      fan_q <= {fan1_stall,
                fan_alarm_speed,
                fan2_stall,
                4'h0,
                alert_low};
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_local_high: assert property (@(posedge clk) disable iff (!rst_n)
    conv_local.done && !sw_rst |=> temp_q[7] == $past(conv_local.high))
    else $error("local high flag wrong");
  a_rem1_low: assert property (@(posedge clk) disable iff (!rst_n)
    conv_rem1.done && !sw_rst |=> temp_q[4] == $past(conv_rem1.low))
    else $error("remote1 low flag wrong");
  a_rem1_fault: assert property (@(posedge clk) disable iff (!rst_n)
    !conv_rem1.done && !sw_rst |=> $stable(temp_q[3]))
    else $error("remote1 fault moved between conversions");
  a_rem2_fault: assert property (@(posedge clk) disable iff (!rst_n)
    conv_rem2.done && !sw_rst |=> temp_q[0] == $past(conv_rem2.fault))
    else $error("remote2 fault flag wrong");
  a_rem2_high: assert property (@(posedge clk) disable iff (!rst_n)
    conv_rem2.done && !sw_rst |=> temp_q[2] == $past(conv_rem2.high))
    else $error("remote2 high flag wrong");
  a_ovh_trip: assert property (@(posedge clk) disable iff (!rst_n)
    conv_rem1.done && !sw_rst |=> ovh_q[6] == $past(conv_rem1.ovh))
    else $error("remote1 overheat flag wrong");
  a_exceed_set: assert property (@(posedge clk) disable iff (!rst_n)
    exceed && !sw_rst |=> ovh_q[4])
    else $error("duty exceeded not set");
  a_read_clear: assert property (@(posedge clk) disable iff (!rst_n)
    rd_ovh && !exceed |=> !ovh_q[4])
    else $error("duty exceeded not cleared by read");
  a_zero_limit: assert property (@(posedge clk) disable iff (!rst_n)
    dlim_q == 8'h00 && line_act && rd_ovh && !sw_rst |=> ovh_q[4])
    else $error("zero limit flag not reasserted");
  a_input_seen: assert property (@(posedge clk) disable iff (!rst_n)
    !sw_rst |=> ovh_q[3] == ($past(!overheat_line_in) && !$past(overheat_drive_state)))
    else $error("input seen flag wrong");
  a_drive_state: assert property (@(posedge clk) disable iff (!rst_n)
    !sw_rst |=> ovh_q[2] == $past(overheat_drive_state))
    else $error("drive state flag wrong");
  a_fan_bits: assert property (@(posedge clk) disable iff (!rst_n)
    !sw_rst |=> fan_q == {$past(fan1_stall), $past(fan_alarm_speed),
                          $past(fan2_stall), 4'h0, $past(alert_low)})
    else $error("fan status wrong");
  a_sw_clear: assert property (@(posedge clk) disable iff (!rst_n)
    sw_rst |=> temp_q == 8'h00 && ovh_q == 8'h00 && fan_q == 8'h00 && duty_q == 8'h00)
    else $error("software reset did not clear");
  a_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    ovh_q[1:0] == 2'b00 && fan_q[4:1] == 4'h0)
    else $error("reserved bit set");
  a_duty_range: assert property (@(posedge clk) disable iff (!rst_n)
    duty_q <= TFS_PCT_FULL)
    else $error("duty above full");
  a_duty_wr: assert property (@(posedge clk) disable iff (!rst_n)
    req && wb_we_i && hit(wb_adr_i, TFS_IDX_DUTY) && !win_end |=> $stable(duty_q))
    else $error("duty changed by write");
  a_ack_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_local_low: assert property (@(posedge clk) disable iff (!rst_n)
    conv_local.done && !sw_rst |=> temp_q[6] == $past(conv_local.low))
    else $error("local low flag wrong");
  a_rem1_high: assert property (@(posedge clk) disable iff (!rst_n)
    conv_rem1.done && !sw_rst |=> temp_q[5] == $past(conv_rem1.high))
    else $error("remote1 high flag wrong");
  a_rem1_fset: assert property (@(posedge clk) disable iff (!rst_n)
    conv_rem1.done && !sw_rst |=> temp_q[3] == $past(conv_rem1.fault))
    else $error("remote1 fault flag wrong");
  a_rem2_low: assert property (@(posedge clk) disable iff (!rst_n)
    conv_rem2.done && !sw_rst |=> temp_q[1] == $past(conv_rem2.low))
    else $error("remote2 low flag wrong");
  a_rem2_fhold: assert property (@(posedge clk) disable iff (!rst_n)
    !conv_rem2.done && !sw_rst |=> $stable(temp_q[0]))
    else $error("remote2 fault moved between conversions");
  a_local_trip: assert property (@(posedge clk) disable iff (!rst_n)
    conv_local.done && !sw_rst |=> ovh_q[7] == $past(conv_local.ovh))
    else $error("local overheat flag wrong");
  a_rem2_trip: assert property (@(posedge clk) disable iff (!rst_n)
    conv_rem2.done && !sw_rst |=> ovh_q[5] == $past(conv_rem2.ovh))
    else $error("remote2 overheat flag wrong");
  a_trip_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !conv_rem1.done && !sw_rst |=> $stable(ovh_q[6]))
    else $error("remote1 overheat moved between conversions");
  a_local_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !conv_local.done && !sw_rst |=> $stable(temp_q[7:6]))
    else $error("local flags moved between conversions");
  a_rem1_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !conv_rem1.done && !sw_rst |=> $stable(temp_q[5:4]))
    else $error("remote1 flags moved between conversions");
  a_exceed_hold: assert property (@(posedge clk) disable iff (!rst_n)
    ovh_q[4] && !rd_ovh && !sw_rst |=> ovh_q[4])
    else $error("duty exceeded lost without read");
  a_no_false_set: assert property (@(posedge clk) disable iff (!rst_n)
    !ovh_q[4] && !exceed |=> !ovh_q[4])
    else $error("duty exceeded set without cause");
  a_exceed_zero: assert property (@(posedge clk) disable iff (!rst_n)
    dlim_q == 8'h00 && line_act && !sw_rst |=> ovh_q[4])
    else $error("zero limit flag missing");
  a_dlim_wr: assert property (@(posedge clk) disable iff (!rst_n)
    wr_dlim |=> dlim_q == $past(wb_dat_i[7:0]))
    else $error("duty limit write lost");
  a_dlim_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_dlim |=> $stable(dlim_q))
    else $error("duty limit changed without write");
  a_line_owner: assert property (@(posedge clk) disable iff (!rst_n)
    ovh_q[2] |-> !ovh_q[3])
    else $error("input seen while device drives");
  a_fan1_bit: assert property (@(posedge clk) disable iff (!rst_n)
    !sw_rst |=> fan_q[7] == $past(fan1_stall))
    else $error("fan1 stall flag wrong");
  a_fan2_bit: assert property (@(posedge clk) disable iff (!rst_n)
    !sw_rst |=> fan_q[5] == $past(fan2_stall))
    else $error("fan2 stall flag wrong");
  a_alarm_bit: assert property (@(posedge clk) disable iff (!rst_n)
    !sw_rst |=> fan_q[6] == $past(fan_alarm_speed))
    else $error("alarm speed flag wrong");
  a_alert_bit: assert property (@(posedge clk) disable iff (!rst_n)
    !sw_rst |=> fan_q[0] == $past(alert_low))
    else $error("alert flag wrong");
  a_temp_wr: assert property (@(posedge clk) disable iff (!rst_n)
    req && wb_we_i && !sw_rst && !conv_local.done && !conv_rem1.done
      && !conv_rem2.done |=> $stable(temp_q))
    else $error("temp status changed by write");
  a_duty_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !win_end && !sw_rst |=> $stable(duty_q))
    else $error("duty moved inside window");
  a_win_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    win_end && !sw_rst |=> win_cnt_q == 32'h0000_0000)
    else $error("window did not restart");
  a_win_bound: assert property (@(posedge clk) disable iff (!rst_n)
    win_cnt_q < 32'(WIN_CYC))
    else $error("window counter past end");
  a_on_bound: assert property (@(posedge clk) disable iff (!rst_n)
    on_cnt_q <= win_cnt_q)
    else $error("on count above window count");

  // ---------------------------------------------------------------
  // read path checks
  // ---------------------------------------------------------------
  a_ack_follow: assert property (@(posedge clk) disable iff (!rst_n)
    req |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ack_cause: assert property (@(posedge clk) disable iff (!rst_n)
    !req |=> !wb_ack_o)
    else $error("ack without request");
  a_rd_upper: assert property (@(posedge clk) disable iff (!rst_n)
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_rd_duty: assert property (@(posedge clk) disable iff (!rst_n)
    req && !wb_we_i && hit(wb_adr_i, TFS_IDX_DUTY) |=> wb_dat_o[7:0] == $past(duty_q))
    else $error("duty read wrong");
  a_rd_temp: assert property (@(posedge clk) disable iff (!rst_n)
    req && !wb_we_i && hit(wb_adr_i, TFS_IDX_TEMP) |=> wb_dat_o[7:0] == $past(temp_q))
    else $error("temp status read wrong");
  a_rd_ovh: assert property (@(posedge clk) disable iff (!rst_n)
    rd_ovh |=> wb_dat_o[7:0] == $past(ovh_q))
    else $error("overheat status read wrong");
  a_rd_fan: assert property (@(posedge clk) disable iff (!rst_n)
    req && !wb_we_i && hit(wb_adr_i, TFS_IDX_FAN) |=> wb_dat_o[7:0] == $past(fan_q))
    else $error("fan status read wrong");
  a_rd_dlim: assert property (@(posedge clk) disable iff (!rst_n)
    req && !wb_we_i && hit(wb_adr_i, TFS_IDX_DLIM) |=> wb_dat_o[7:0] == $past(dlim_q))
    else $error("duty limit read wrong");

endmodule
`default_nettype wire

// ---- test/tfs_pin_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// -----------------------------------------------
// overheat pin: open drain wire with pull-up
// -----------------------------------------------
module tfs_pin_model (
  input  wire logic ext_low,
  input  wire logic dev_drive,
  output logic      line
);
  // either party pulling low wins; released wire floats high
  assign line = !(ext_low || dev_drive);
endmodule
`default_nettype wire

// ---- test/test_tfs_status_bank.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_tfs_status_bank;
  import tfs_pkg::*;
  localparam int WIN = 200;
  logic        clk, rst_n, cyc, stb, we, ext_low, drv, line;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_i, dat_o;
  logic        ack, f1, f2, fal, alr;
  tfs_conv_t   c_l, c_1, c_2;
  int          err_total, checked;
  logic [7:0]  rd;

  tfs_status_bank #(.WIN_CYC(WIN)) i_tfs_status_bank (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .conv_local(c_l), .conv_rem1(c_1), .conv_rem2(c_2),
    .overheat_line_in(line), .overheat_drive_state(drv), .fan1_stall(f1),
    .fan2_stall(f2), .fan_alarm_speed(fal), .alert_low(alr));
  tfs_pin_model i_tfs_pin_model (.ext_low(ext_low), .dev_drive(drv), .line(line));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic complete_run();
    $display("counts: checked %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one classic cycle; waits for ack under a bound
  task automatic bus(logic w, logic [7:0] idx, logic [7:0] wd);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; dat_i <= {24'h0, wd};
    sel <= 4'hF;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    if (n == 20) begin
      err_total++;
      complete_run();
    end
    rd = dat_o[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic rchk(string nm, logic [7:0] idx, logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(nm, exp, rd);
  endtask

  // one conversion end on all three channels: {high,low,fault,ovh}
  task automatic conv(logic [3:0] l, logic [3:0] r1, logic [3:0] r2);
    @(posedge clk);
    c_l <= {1'b1, l}; c_1 <= {1'b1, r1}; c_2 <= {1'b1, r2};
    @(posedge clk);
    c_l <= 5'h00; c_1 <= 5'h00; c_2 <= 5'h00;
  endtask

  task automatic idle(int n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    err_total = 0; checked = 0; rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 10'h000; sel = 4'h0; dat_i = 32'h0; ext_low = 1'b0; drv = 1'b0;
    f1 = 1'b0; f2 = 1'b0; fal = 1'b0; alr = 1'b0; c_l = 5'h00; c_1 = 5'h00; c_2 = 5'h00;
    idle(3);
    rst_n <= 1'b1;
    rchk("duty", TFS_IDX_DUTY, 8'h00);
    rchk("temp", TFS_IDX_TEMP, 8'h00);
    rchk("ovh", TFS_IDX_OVH, 8'h00);
    rchk("fan", TFS_IDX_FAN, 8'h00);
    rchk("unmapped", 8'hFF, 8'h00);
    $display("test reset_values done");
    conv(4'b1100, 4'b1110, 4'b1110);
    rchk("temp_all", TFS_IDX_TEMP, 8'hFF);
    bus(1'b1, TFS_IDX_TEMP, 8'h00);
    rchk("temp_wr", TFS_IDX_TEMP, 8'hFF);
    conv(4'b1000, 4'b0000, 4'b0010);
    rchk("temp_some", TFS_IDX_TEMP, 8'h81);
    conv(4'b0001, 4'b0001, 4'b0001);
    rchk("temp_clr", TFS_IDX_TEMP, 8'h00);
    rchk("ovh_trip", TFS_IDX_OVH, 8'hE0);
    $display("test temp_and_trip done");
    ext_low <= 1'b1;
    idle(3);
    rchk("ovh_in", TFS_IDX_OVH, 8'hF8);
    rchk("ovh_reassert", TFS_IDX_OVH, 8'hF8);
    ext_low <= 1'b0; drv <= 1'b1;
    idle(3);
    rchk("ovh_drive", TFS_IDX_OVH, 8'hF4);
    idle(2 * WIN + 50);
    rchk("duty_full", TFS_IDX_DUTY, 8'h64);
    bus(1'b1, TFS_IDX_DUTY, 8'h55);
    rchk("duty_wr", TFS_IDX_DUTY, 8'h64);
    bus(1'b1, TFS_IDX_OVH, 8'h03);
    drv <= 1'b0;
    idle(3);
    rchk("ovh_sticky", TFS_IDX_OVH, 8'hF0);
    rchk("ovh_cleared", TFS_IDX_OVH, 8'hE0);
    $display("test overheat_line done");
    f1 <= 1'b1; f2 <= 1'b1; fal <= 1'b1; alr <= 1'b1;
    idle(3);
    rchk("fan_all", TFS_IDX_FAN, 8'hE1);
    f1 <= 1'b0; fal <= 1'b0; alr <= 1'b0;
    idle(3);
    rchk("fan_two", TFS_IDX_FAN, 8'h20);
    $display("test fan done");
    bus(1'b1, TFS_IDX_CTRL, 8'h01);
    rchk("sw_duty", TFS_IDX_DUTY, 8'h00);
    rchk("sw_temp", TFS_IDX_TEMP, 8'h00);
    rchk("sw_ovh", TFS_IDX_OVH, 8'h00);
    f2 <= 1'b0;
    idle(3);
    rchk("sw_fan", TFS_IDX_FAN, 8'h00);
    bus(1'b1, TFS_IDX_DLIM, 8'h32);
    rchk("dlim", TFS_IDX_DLIM, 8'h32);
    $display("test software_reset done");
    complete_run();
  end
endmodule
`default_nettype wire
